// ---- pswfp_pkg.sv ----
// Package for the power switch fault protection sequencer.
// Assumes a single 40 MHz clock and a synchronous active-high reset.
package pswfp_pkg;

    // Clock rate.
    localparam int unsigned CLOCK_HZ           = 40_000_000;

    // Undervoltage filter time in microseconds, and its count (exact at this clock, no rounding).
    localparam int unsigned UV_FILTER_US       = 20;
    localparam int unsigned UV_FILTER_CYCLES   = (UV_FILTER_US * (CLOCK_HZ / 1_000_000));

    // Undervoltage alarm hold time in microseconds (plain default) and its count.
    localparam int unsigned UV_HOLD_US         = 2000;
    localparam int unsigned UV_HOLD_CYCLES     = UV_HOLD_US * (CLOCK_HZ / 1_000_000);

    // Overcurrent trip delay in nanoseconds (plain default) and its count.
    localparam int unsigned OC_DELAY_NS        = 5000;
    localparam int unsigned OC_DELAY_CYCLES    = (OC_DELAY_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;

    // Overcurrent alarm hold time in milliseconds and its count.
    localparam int unsigned OC_HOLD_MS         = 2;
    localparam int unsigned OC_HOLD_CYCLES     = OC_HOLD_MS * (CLOCK_HZ / 1000);

    // Counter width shared by all timers.
    localparam int unsigned TIMER_W            = 24;

    // Reset values.
    localparam logic        ALARM_N_RESET      = 1'b1;
    localparam logic        GATE_RESET         = 1'b0;

    // Protection channel states.
    typedef enum logic [3:0] {
        PSWFP_IDLE    = 4'h1,
        PSWFP_FILTER  = 4'h2,
        PSWFP_HOLD    = 4'h4,
        PSWFP_LATCHED = 4'h8
    } pswfp_state_e;

endpackage : pswfp_pkg

// ---- pswfp_channel.sv ----
// One protection channel: debounce timer, alarm hold timer and release gating.
// Assumes its fault and drive inputs are already synchronous to clock.
`timescale 1ns/10ps
module pswfp_channel
#(
    parameter int unsigned FILTER_CYCLES = 1,
    parameter int unsigned HOLD_CYCLES   = 1,
    parameter bit          CANCEL_ON_OFF = 1'b0
)
(
    // Clock and reset.
    input  wire logic clock,
    input  wire logic rst,
    // Conditions.
    input  wire logic fault_raw,
    input  wire logic fault_clear,
    input  wire logic drive_on,
    input  wire logic enable,
    // Results.
    output logic      protect,
    output logic      alarm,
    output logic      trip_pulse
);
    import pswfp_pkg::*;

    pswfp_state_e       state_q;
    logic [TIMER_W-1:0] timer_q;
    logic               alarm_q;
    logic               trip_q;

    localparam logic [TIMER_W-1:0] FILTER_LAST = TIMER_W'(FILTER_CYCLES - 1);
    localparam logic [TIMER_W-1:0] HOLD_LAST   = TIMER_W'(HOLD_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: filter, hold for the alarm time, then wait for release.
    always_ff @(posedge clock)
    begin
        trip_q <= 1'b0;
        if (rst || !enable)
        begin
            state_q <= PSWFP_IDLE;
            timer_q <= '0;
            alarm_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                PSWFP_IDLE:
                begin
                    timer_q <= '0;
                    if (fault_raw && !(CANCEL_ON_OFF && !drive_on))
                    begin
                        state_q <= PSWFP_FILTER;
                    end
                end
                PSWFP_FILTER:
                begin
                    // Short episodes drop back without any effect.
                    if (!fault_raw || (CANCEL_ON_OFF && !drive_on))
                    begin
                        state_q <= PSWFP_IDLE;
                        timer_q <= '0;
                    end
                    else if (timer_q >= FILTER_LAST)
                    begin
                        state_q <= PSWFP_HOLD;
                        timer_q <= '0;
                        alarm_q <= 1'b1;
                        trip_q  <= 1'b1;
                    end
                    else
                    begin
                        timer_q <= timer_q + 1'b1;
                    end
                end
                PSWFP_HOLD:
                begin
                    // Hold runs to the end regardless of the cause clearing.
                    if (timer_q >= HOLD_LAST)
                    begin
                        alarm_q <= 1'b0;
                        state_q <= PSWFP_LATCHED;
                    end
                    else
                    begin
                        timer_q <= timer_q + 1'b1;
                    end
                end
                PSWFP_LATCHED:
                begin
                    // Release needs the cause gone and the drive input off.
                    if (fault_clear && !drive_on)
                    begin
                        state_q <= PSWFP_IDLE;
                    end
                end
            endcase
        end
    end

    assign protect    = (state_q == PSWFP_HOLD) || (state_q == PSWFP_LATCHED);
    assign alarm      = alarm_q;
    assign trip_pulse = trip_q;

endmodule : pswfp_channel

// ---- pswfp_top.sv ----
// Fault protection sequencer for one power switch driver channel.
// Assumes comparator outputs and the drive pin arrive asynchronously to clock.
//
// Notes on behaviour
// - Undervoltage shorter than 20 us is ignored.
// - Alarm 20 us after sustained undervoltage.
// - Undervoltage with drive on: alarm, soft off.
// - Undervoltage protection lasts the whole hold.
// - Drive on at hold end: alarm ends, protected.
// - Resume needs drive off and supply recovered.
// - One alarm pulse per protection episode.
// - Startup above 5 V below threshold alarms.
// - Protect until supply above hysteresis, drive off.
// - Shutdown below threshold alarms after 20 us.
// - Below 5 V logic stops, alarm goes high.
// - Overcurrent beyond delay: alarm and soft off.
// - Overcurrent holds protection about 2 ms.
// - Drive on at hold end keeps protection.
// - Drive off before delay: no trip, normal off.
`timescale 1ns/10ps
module pswfp_top
(
    // Clock and reset.
    input  wire logic clock,
    input  wire logic rst,
    // Drive command from the controller, low commands on.
    input  wire logic drive_in_n,
    // Analog comparator results.
    input  wire logic supply_above_5v,
    input  wire logic supply_below_threshold,
    input  wire logic supply_above_hysteresis,
    input  wire logic current_above_trip_level,
    // Gate drive and alarm.
    output logic      gate_on,
    output logic      soft_turn_off,
    output logic      fault_alarm_output_n
);
    import pswfp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Three-stage synchronisers; a change counts once stages two and three agree.
    logic [2:0] s_drv_q;
    logic [2:0] s_5v_q;
    logic [2:0] s_uv_q;
    logic [2:0] s_hy_q;
    logic [2:0] s_oc_q;
    logic       drv_on_q;
    logic       ok5_q;
    logic       uv_q;
    logic       hy_q;
    logic       oc_q;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s_drv_q <= 3'h7;
            s_5v_q  <= 3'h0;
            s_uv_q  <= 3'h0;
            s_hy_q  <= 3'h0;
            s_oc_q  <= 3'h0;
        end
        else
        begin
            s_drv_q <= {s_drv_q[1:0], drive_in_n};
            s_5v_q  <= {s_5v_q[1:0], supply_above_5v};
            s_uv_q  <= {s_uv_q[1:0], supply_below_threshold};
            s_hy_q  <= {s_hy_q[1:0], supply_above_hysteresis};
            s_oc_q  <= {s_oc_q[1:0], current_above_trip_level};
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            drv_on_q <= 1'b0;
            ok5_q    <= 1'b0;
            uv_q     <= 1'b0;
            hy_q     <= 1'b0;
            oc_q     <= 1'b0;
        end
        else
        begin
            if (s_drv_q[1] == s_drv_q[2])
            begin
                drv_on_q <= !s_drv_q[2];
            end
            if (s_5v_q[1] == s_5v_q[2])
            begin
                ok5_q <= s_5v_q[2];
            end
            if (s_uv_q[1] == s_uv_q[2])
            begin
                uv_q <= s_uv_q[2];
            end
            if (s_hy_q[1] == s_hy_q[2])
            begin
                hy_q <= s_hy_q[2];
            end
            if (s_oc_q[1] == s_oc_q[2])
            begin
                oc_q <= s_oc_q[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Independent channels for undervoltage and overcurrent.
    logic uv_protect;
    logic uv_alarm;
    logic uv_trip;
    logic oc_protect;
    logic oc_alarm;
    logic oc_trip;

    // The undervoltage channel runs only above 5 V, covering startup and shutdown.
    pswfp_channel
    #(
        .FILTER_CYCLES (UV_FILTER_CYCLES),
        .HOLD_CYCLES   (UV_HOLD_CYCLES),
        .CANCEL_ON_OFF (1'b0)
    )
    u_uv
    (
        .clock       (clock),
        .rst         (rst),
        .fault_raw   (uv_q),
        .fault_clear (hy_q),
        .drive_on    (drv_on_q),
        .enable      (ok5_q),
        .protect     (uv_protect),
        .alarm       (uv_alarm),
        .trip_pulse  (uv_trip)
    );

    // Overcurrent is only meaningful while the switch conducts.
    pswfp_channel
    #(
        .FILTER_CYCLES (OC_DELAY_CYCLES),
        .HOLD_CYCLES   (OC_HOLD_CYCLES),
        .CANCEL_ON_OFF (1'b1)
    )
    u_oc
    (
        .clock       (clock),
        .rst         (rst),
        .fault_raw   (oc_q && gate_on),
        .fault_clear (1'b1),
        .drive_on    (drv_on_q),
        .enable      (ok5_q),
        .protect     (oc_protect),
        .alarm       (oc_alarm),
        .trip_pulse  (oc_trip)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Gate and alarm outputs, all registered.
    logic protect_any;

    assign protect_any = uv_protect || oc_protect || !ok5_q;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            gate_on       <= GATE_RESET;
            soft_turn_off <= 1'b0;
        end
        else
        begin
            gate_on <= drv_on_q && !protect_any;
            // Soft mode is chosen on a trip with the switch on; a plain off stays normal.
            if ((uv_trip || oc_trip) && gate_on)
            begin
                soft_turn_off <= 1'b1;
            end
            else if (!protect_any)
            begin
                soft_turn_off <= 1'b0;
            end
        end
    end

    // Alarm is low for each hold period and high when logic is unpowered.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            fault_alarm_output_n <= ALARM_N_RESET;
        end
        else
        begin
            fault_alarm_output_n <= !((uv_alarm || oc_alarm) && ok5_q);
        end
    end

endmodule : pswfp_top

// ---- pswfp_top_properties.sv ----
// Concurrent checks for the power switch fault protection sequencer.
// Assumes it is bound to pswfp_top and sees only that module's ports.
`timescale 1ns/10ps
module pswfp_checker
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Sequencer inputs.
    input wire logic drive_in_n,
    input wire logic supply_above_5v,
    input wire logic supply_below_threshold,
    input wire logic supply_above_hysteresis,
    input wire logic current_above_trip_level,
    // Sequencer outputs.
    input wire logic gate_on,
    input wire logic soft_turn_off,
    input wire logic fault_alarm_output_n
);
    import pswfp_pkg::*;
    localparam int unsigned UV_LATE = UV_FILTER_CYCLES + 20;
    logic [15:0] uv_run_q;
    // Counts how long the supply has stayed low with the logic powered.
    always_ff @(posedge clock)
    begin
        if (rst || !supply_below_threshold || !supply_above_5v)
            uv_run_q <= 16'h0000;
        else if (uv_run_q != 16'hFFFF)
            uv_run_q <= uv_run_q + 16'h0001;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence alarm_start_s;
        $fell(fault_alarm_output_n) && supply_above_5v;
    endsequence
    sequence alarm_held_s;
        (!fault_alarm_output_n || !supply_above_5v) [*8];
    endsequence
    reset_state_a: assert property (disable iff (1'b0) rst |=> fault_alarm_output_n && !gate_on && !soft_turn_off)
        else $error("outputs not at rest after reset");
    uv_late_a: assert property (uv_run_q == 16'(UV_LATE) |-> !fault_alarm_output_n)
        else $error("no alarm after sustained undervoltage");
    alarm_cause_a: assert property ($fell(fault_alarm_output_n) |->
        $past(supply_below_threshold, 100) || $past(current_above_trip_level, 100))
        else $error("alarm without a lasting fault");
    alarm_hold_a: assert property (alarm_start_s |=> alarm_held_s)
        else $error("alarm pulse too short");
    gate_blocked_a: assert property (!fault_alarm_output_n && !$past(fault_alarm_output_n) |-> !gate_on)
        else $error("gate on during alarm");
    gate_cmd_a: assert property ($rose(gate_on) |-> $past(!drive_in_n, 4) && $past(supply_above_5v, 4))
        else $error("gate on without drive command");
    soft_trip_a: assert property ($fell(fault_alarm_output_n) && $past(gate_on) |-> ##[0:2] soft_turn_off)
        else $error("trip without soft turn off");
    normal_off_a: assert property ($fell(gate_on) && fault_alarm_output_n ##1 fault_alarm_output_n [*3]
        |-> !soft_turn_off)
        else $error("soft turn off without trip");
    low_supply_a: assert property (!supply_above_5v [*8] |-> fault_alarm_output_n && !gate_on)
        else $error("outputs active below 5 V");
endmodule : pswfp_checker
bind pswfp_top pswfp_checker u_checker (.clock(clock), .rst(rst), .drive_in_n(drive_in_n),
    .supply_above_5v(supply_above_5v), .supply_below_threshold(supply_below_threshold),
    .supply_above_hysteresis(supply_above_hysteresis), .current_above_trip_level(current_above_trip_level),
    .gate_on(gate_on), .soft_turn_off(soft_turn_off), .fault_alarm_output_n(fault_alarm_output_n));

// ---- pswfp_controller.sv ----
// Model of the inverter controller that drives the switch input and reads the alarm.
// Assumes the bench sets want_on between clock edges.
`timescale 1ns/10ps
module pswfp_controller
(
    // Clock.
    input wire logic clock,
    // Bench command and observed alarm.
    input wire logic want_on,
    input wire logic fault_alarm_output_n,
    // Drive pin and pulse count.
    output logic     drive_in_n,
    output int       alarm_pulses
);
    logic want_q = 1'b0;
    initial drive_in_n = 1'b1;
    initial alarm_pulses = 0;
    // Taking the command on a rising edge keeps it clear of the bench's own falling edge; the pin then changes on a falling edge.
    always @(posedge clock) want_q <= want_on;
    // A low level on the pin commands the switch on.
    always @(negedge clock) drive_in_n <= !want_q;
    // Any number of pulses is accepted; they are only counted.
    always @(negedge fault_alarm_output_n) alarm_pulses <= alarm_pulses + 1;
endmodule : pswfp_controller

// ---- pswfp_bench.sv ----
// Self-checking bench for the power switch fault protection sequencer.
// Assumes the package hold times as shipped; the run stays under 90000 cycles.
`timescale 1ns/10ps
module pswfp_bench;
    import pswfp_pkg::*;
    logic clock = 1'b0, rst = 1'b1, want_on = 1'b0, drive_in_n;
    logic s5v = 1'b1, below = 1'b0, hyst = 1'b1, cur = 1'b0;
    logic gate_on, soft_turn_off, fault_alarm_output_n;
    int   error_cnt = 0, checked = 0, cycles = 0, low_seen = 0, pulses;
    always #12.5 clock = ~clock;
    pswfp_controller ctl (.clock(clock), .want_on(want_on), .fault_alarm_output_n(fault_alarm_output_n),
        .drive_in_n(drive_in_n), .alarm_pulses(pulses));
    pswfp_top dut (.clock(clock), .rst(rst), .drive_in_n(drive_in_n), .supply_above_5v(s5v),
        .supply_below_threshold(below), .supply_above_hysteresis(hyst), .current_above_trip_level(cur),
        .gate_on(gate_on), .soft_turn_off(soft_turn_off), .fault_alarm_output_n(fault_alarm_output_n));
    task automatic tally_and_finish();
        $display("Counts: %0d checks, %0d mismatches", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            error_cnt++;
            $display("Error at %0t: run too long", $time);
            tally_and_finish();
        end
    end
    task automatic check_bit(input logic actual, input logic expected);
        checked++;
        if (actual !== expected)
        begin
            error_cnt++;
            $display("Error at %0t: output %b, expected %b", $time, actual, expected);
        end
    endtask : check_bit
    task automatic check_range(input int value, input int lo, input int hi);
        checked++;
        if (value < lo || value > hi)
        begin
            error_cnt++;
            $display("Error at %0t: count %0d outside %0d..%0d", $time, value, lo, hi);
        end
    endtask : check_range
    task automatic run(input int n);
        repeat (n)
        begin
            @(negedge clock);
            if (fault_alarm_output_n !== 1'b1) low_seen++;
        end
    endtask : run
    task automatic wait_alarm(input logic level, input int limit, output int t);
        t = 0;
        while (fault_alarm_output_n !== level && t < limit)
        begin
            @(negedge clock);
            t++;
        end
    endtask : wait_alarm
    task automatic test_normal();
        want_on = 1'b1;
        run(12);
        check_bit(gate_on, 1'b1);
        want_on = 1'b0;
        run(12);
        check_bit(gate_on, 1'b0);
        check_bit(soft_turn_off, 1'b0);
        $display("test_normal done");
    endtask : test_normal
    task automatic test_glitches();
        want_on = 1'b1;
        run(12);
        low_seen = 0;
        below = 1'b1;
        run(UV_FILTER_CYCLES / 2);
        below = 1'b0;
        run(600);
        check_range(low_seen, 0, 0);
        check_bit(gate_on, 1'b1);
        cur = 1'b1;
        run(OC_DELAY_CYCLES / 2);
        want_on = 1'b0;
        run(400);
        cur = 1'b0;
        check_range(low_seen, 0, 0);
        check_bit(soft_turn_off, 1'b0);
        $display("test_glitches done");
    endtask : test_glitches
    task automatic test_oc_trip();
        int t;
        int p0;
        want_on = 1'b1;
        run(12);
        p0 = pulses;
        cur = 1'b1;
        wait_alarm(1'b0, 500, t);
        check_range(t, OC_DELAY_CYCLES, OC_DELAY_CYCLES + 12);
        run(2);
        check_bit(gate_on, 1'b0);
        check_bit(soft_turn_off, 1'b1);
        cur = 1'b0;
        wait_alarm(1'b1, OC_HOLD_CYCLES + 50, t);
        check_range(t, OC_HOLD_CYCLES - 4, OC_HOLD_CYCLES + 12);
        run(200);
        check_bit(gate_on, 1'b0);
        check_range(pulses - p0, 1, 1);
        want_on = 1'b0;
        run(12);
        want_on = 1'b1;
        run(12);
        check_bit(gate_on, 1'b1);
        $display("test_oc_trip done");
    endtask : test_oc_trip
    task automatic test_uv_trip();
        int t;
        int p0;
        p0 = pulses;
        below = 1'b1;
        hyst = 1'b0;
        wait_alarm(1'b0, 1000, t);
        check_range(t, UV_FILTER_CYCLES, UV_FILTER_CYCLES + 12);
        run(20);
        check_bit(gate_on, 1'b0);
        check_bit(soft_turn_off, 1'b1);
        below = 1'b0;
        hyst = 1'b1;
        want_on = 1'b0;
        run(200);
        check_bit(fault_alarm_output_n, 1'b0);
        check_range(pulses - p0, 1, 1);
        s5v = 1'b0;
        run(12);
        check_bit(fault_alarm_output_n, 1'b1);
        check_bit(gate_on, 1'b0);
        s5v = 1'b1;
        run(20);
        $display("test_uv_trip done");
    endtask : test_uv_trip
    initial
    begin
        repeat (8) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        check_bit(fault_alarm_output_n, 1'b1);
        check_bit(gate_on, 1'b0);
        test_normal();
        test_glitches();
        test_oc_trip();
        test_uv_trip();
        tally_and_finish();
    end
endmodule : pswfp_bench
